/* hw/clocked_micro_port.sv */
/*
  Clock-synchronous 8-bit microprocessor port with two protocol
  styles (separate read/write strobes, or data strobe plus direction)
  and a ready/acknowledge handshake counted in clock edges.
  Assumes all host pins are asynchronous to CLK; each passes two flops.
*/
`timescale 1ns/10ps
`include "micro_port_defines.svh"

module clocked_micro_port
  import micro_port_pkg::*;
(
  input  wire logic             CLK,
  input  wire logic             SYS_RST,
  input  wire logic             MODE,
  input  wire logic             CS_N,
  input  micro_port_pkg::addr_t ADDR,
  input  wire logic             DATA_STROBE_N,
  input  wire logic             WRITE_SEL_N,
  input  micro_port_pkg::byte_t D_I,
  output micro_port_pkg::byte_t D_O,
  output logic                  D_OE_N,
  output logic                  TRANSFER_ACK_N,
  output logic                  WR_STB,
  output micro_port_pkg::addr_t WR_ADDR,
  output micro_port_pkg::byte_t WR_DATA
);

  // ****************************************
  // Pin synchronisers
  // ****************************************
  logic  [3:0] ctl_s1_r;
  logic  [3:0] ctl_s2_r;
  addr_t       addr_s1_r;
  addr_t       addr_s2_r;
  byte_t       din_s1_r;
  byte_t       din_s2_r;

  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      ctl_s1_r  <= 4'hF;
      ctl_s2_r  <= 4'hF;
      addr_s1_r <= '0;
      addr_s2_r <= '0;
      din_s1_r  <= '0;
      din_s2_r  <= '0;
    end else begin
      ctl_s1_r  <= {MODE, CS_N, DATA_STROBE_N, WRITE_SEL_N};
      ctl_s2_r  <= ctl_s1_r;
      addr_s1_r <= ADDR;
      addr_s2_r <= addr_s1_r;
      din_s1_r  <= D_I;
      din_s2_r  <= din_s1_r;
    end
  end

  // ****************************************
  // Access decode
  // ****************************************
  wire mode1     = ctl_s2_r[3];
  wire cs_low    = ~ctl_s2_r[2];
  wire strb_low  = ~ctl_s2_r[1];
  wire wsel_low  = ~ctl_s2_r[0];
  wire rd_req0   = strb_low & ~wsel_low;
  wire wr_req0   = wsel_low & ~strb_low;
  wire req1      = strb_low;
  wire start     = cs_low & (mode1 ? req1 : (rd_req0 | wr_req0));
  wire start_wr  = mode1 ? wsel_low : wr_req0;
  wire addr_int  = (addr_s2_r == `MP_ADDR_INT);

  // Edge count to the turnaround point for the access being started
  wire [2:0] edges_rd  = mode1 ? (addr_int ? `MP_RD1_EDGES_INT : `MP_RD1_EDGES)
                               : (addr_int ? `MP_RD0_EDGES_INT : `MP_RD0_EDGES);
  wire [2:0] edges_wr  = mode1 ? `MP_WR1_EDGES : `MP_WR0_EDGES;
  wire [2:0] edges_sel = start_wr ? edges_wr : edges_rd;

  // ****************************************
  // Transaction sequencer
  // ****************************************
  port_state_e state_r;
  port_state_e state_nxt;
  logic  [2:0] cnt_r;
  logic  [2:0] cnt_nxt;
  logic  [2:0] target_r;
  logic        is_wr_r;
  logic        is_m1_r;
  addr_t       addr_r;
  logic        ack_nxt;
  logic        wr_fire;

  wire hit = (cnt_r == target_r);

  // Next-state and handshake selection
  always_comb begin
    state_nxt = state_r;
    cnt_nxt   = cnt_r;
    ack_nxt   = TRANSFER_ACK_N;
    wr_fire   = 1'b0;
    case (state_r)
      ST_IDLE: begin
        cnt_nxt = 3'h1;
        if (start) begin
          state_nxt = ST_WAIT;
          // mode 0 ready drops at sampled start
          ack_nxt = mode1 ? 1'b1 : 1'b0;
        end
      end
      ST_WAIT: begin
        cnt_nxt = cnt_r + 3'h1;
        if (!cs_low) begin
          // Host withdrew before the turnaround: drop the access
          state_nxt = ST_IDLE;
          ack_nxt   = `MP_ACK_IDLE;
        end else if (hit) begin
          state_nxt = ST_DONE;
          ack_nxt = is_m1_r ? 1'b0 : 1'b1;
          wr_fire = is_wr_r;
        end
      end
      ST_DONE: begin
        if (!cs_low) begin
          state_nxt = ST_IDLE;
          ack_nxt   = `MP_ACK_IDLE;
        end
      end
      default: begin
        state_nxt = ST_IDLE;
        ack_nxt   = `MP_ACK_IDLE;
      end
    endcase
  end

  // State, counter and captured access attributes
  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      state_r  <= ST_IDLE;
      cnt_r    <= 3'h1;
      target_r <= 3'h2;
      is_wr_r  <= 1'b0;
      is_m1_r  <= 1'b0;
      addr_r   <= '0;
    end else begin
      state_r <= state_nxt;
      cnt_r   <= cnt_nxt;
      if (state_r == ST_IDLE && start) begin
        target_r <= edges_sel;
        is_wr_r  <= start_wr;
        is_m1_r  <= mode1;
        addr_r   <= addr_s2_r;
      end
    end
  end

  // ****************************************
  // Pin and user-side outputs
  // ****************************************
  byte_t rd_data;
  // drive only while selected and reading
  wire   oe_nxt_n = ~(cs_low & (state_r != ST_IDLE) & ~is_wr_r);

  // handshake pin idles high from reset
  // WR_DATA reloads from the synchronised data bus at every edge
  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      TRANSFER_ACK_N <= `MP_ACK_IDLE;
      D_OE_N         <= `MP_OE_IDLE;
      D_O            <= '0;
      WR_STB         <= 1'b0;
      WR_ADDR        <= '0;
      WR_DATA        <= '0;
    end else begin
      TRANSFER_ACK_N <= ack_nxt;
      D_OE_N         <= oe_nxt_n;
      D_O            <= rd_data;
      WR_STB         <= wr_fire;
      WR_ADDR        <= addr_r;
      WR_DATA        <= din_s2_r;
    end
  end

  // Register store addressed by the captured access
  port_store port_store_inst (
    .clk     (CLK),
    .rst     (SYS_RST),
    .wr_en   (wr_fire),
    .wr_addr (addr_r),
    .wr_data (din_s2_r),
    .rd_addr (addr_r),
    .rd_data (rd_data)
  );

endmodule

/* hw/micro_port_defines.svh */
/*
  Timing counts and sizes for the clocked microprocessor port.
  Assumes inclusion by bare name from the port design files.
*/
`ifndef MICRO_PORT_DEFINES_SVH
`define MICRO_PORT_DEFINES_SVH

// Data and address widths and store depth of the port
`define MP_DATA_W      8
`define MP_ADDR_W      3
`define MP_DEPTH       8
// Address that reaches the internal access path (one extra edge on reads)
`define MP_ADDR_INT    3'h0
// Edges from the sampled start of an access to its turnaround point
`define MP_RD0_EDGES_INT  3'h3
`define MP_RD0_EDGES      3'h2
`define MP_WR0_EDGES      3'h2
`define MP_RD1_EDGES_INT  3'h3
`define MP_RD1_EDGES      3'h2
`define MP_WR1_EDGES      3'h3
// Reset values of the handshake and data-enable outputs
`define MP_ACK_IDLE    1'b1
`define MP_OE_IDLE     1'b1

`endif

/* hw/micro_port_pkg.sv */
/*
  Types shared by the microprocessor port design files.
  Assumes the defines header is available on the include path.
*/
`include "micro_port_defines.svh"

package micro_port_pkg;
  typedef logic [`MP_DATA_W-1:0] byte_t;
  typedef logic [`MP_ADDR_W-1:0] addr_t;
  typedef enum logic [1:0] {ST_IDLE, ST_WAIT, ST_DONE} port_state_e;
endpackage

/* hw/port_store.sv */
/*
  Small register store behind the microprocessor port: eight bytes,
  one write port, one registered read port.
  Assumes a single clock and an active-high asynchronous reset.
*/
`timescale 1ns/10ps
`include "micro_port_defines.svh"

module port_store
  import micro_port_pkg::*;
(
  input  wire logic            clk,
  input  wire logic            rst,
  input  wire logic            wr_en,
  input  micro_port_pkg::addr_t wr_addr,
  input  micro_port_pkg::byte_t wr_data,
  input  micro_port_pkg::addr_t rd_addr,
  output micro_port_pkg::byte_t rd_data
);

  // ****************************************
  // Storage
  // ****************************************
  byte_t mem_r [`MP_DEPTH];

  // One flop row per entry; clears so reads after reset are defined
  genvar g;
  generate
    for (g = 0; g < `MP_DEPTH; g++) begin : g_entry
      always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
          mem_r[g] <= '0;
        end else if (wr_en && wr_addr == addr_t'(g)) begin
          mem_r[g] <= wr_data;
        end
      end
    end
  endgenerate

  // Registered read: data lands one edge after the address
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rd_data <= '0;
    end else begin
      rd_data <= mem_r[rd_addr];
    end
  end

endmodule

/* verif/clocked_micro_port_props.sv */
/*
  Handshake checker bound to every clocked_micro_port.
  Assumes the host holds its pins until each answer is seen.
*/
`timescale 1ns/10ps
module micro_port_chk
  import micro_port_pkg::*;
(
  input wire logic             CLK,
  input wire logic             SYS_RST,
  input wire logic             MODE,
  input wire logic             CS_N,
  input micro_port_pkg::addr_t ADDR,
  input wire logic             DATA_STROBE_N,
  input wire logic             WRITE_SEL_N,
  input micro_port_pkg::byte_t D_I,
  input wire logic             D_OE_N,
  input wire logic             TRANSFER_ACK_N,
  input wire logic             WR_STB,
  input micro_port_pkg::addr_t WR_ADDR,
  input micro_port_pkg::byte_t WR_DATA
);
  // **************************************
  // Start seen at the pins, two flops ahead
  // **************************************
  wire st   = !CS_N && (MODE ? !DATA_STROBE_N : DATA_STROBE_N ^ WRITE_SEL_N);
  wire rd0  = !MODE && !DATA_STROBE_N;
  wire wr0  = !MODE && !WRITE_SEL_N;
  wire hs_n = TRANSFER_ACK_N;
  default clocking @(posedge CLK); endclocking
  default disable iff (SYS_RST);
  a_rd0_rdy: assert property (
    $rose(st) && rd0 |-> ##3 !hs_n [*2] ##1 (hs_n == (ADDR != 3'h0)) ##1 hs_n) else $error("mode0 read ready");
  a_wr0_rdy: assert property (
    $rose(st) && wr0 |-> ##3 !hs_n [*2] ##1 hs_n && WR_STB && WR_ADDR == $past(ADDR, 4)) else $error("mode0 write");
  a_rd1_ack: assert property (
    $rose(st) && MODE && WRITE_SEL_N |-> ##1 hs_n [*4] ##1 (hs_n == (ADDR == 3'h0)) ##1 !hs_n) else $error("mode1 read");
  a_wr1_ack: assert property (
    $rose(st) && MODE && !WRITE_SEL_N |-> ##1 hs_n [*5] ##1 !hs_n && WR_STB && WR_DATA == $past(D_I, 5))
    else $error("mode1 write");
  a_ack1_rel: assert property (MODE && $rose(CS_N) && !hs_n |-> ##3 hs_n)
    else $error("mode1 ack release");
  a_idle_quiet: assert property (CS_N [*4] |=> hs_n && D_OE_N && !WR_STB)
    else $error("deselected port active");
  a_stb_once: assert property (WR_STB |=> !WR_STB)
    else $error("write strobe too long");
  a_rst_idle: assert property ($fell(SYS_RST) |-> hs_n && D_OE_N)
    else $error("not idle after reset");
endmodule
bind clocked_micro_port micro_port_chk micro_port_chk_inst (.CLK, .SYS_RST, .MODE, .CS_N, .ADDR, .DATA_STROBE_N,
  .WRITE_SEL_N, .D_I, .D_OE_N, .TRANSFER_ACK_N, .WR_STB, .WR_ADDR, .WR_DATA);

/* verif/micro_host.sv */
/*
  Host processor model that drives the port pins.
  Assumes its tasks are called from one bench process.
*/
`timescale 1ns/10ps
module micro_host
  import micro_port_pkg::*;
(
  input wire logic              clk,
  input wire logic              ack_n,
  input wire logic              oe_n,
  input micro_port_pkg::byte_t  dout,
  input wire logic              wstb,
  output logic                  mode,
  output logic                  cs_n,
  output micro_port_pkg::addr_t adr,
  output logic                  ds_n,
  output logic                  ws_n,
  output micro_port_pkg::byte_t din
);
  // *******************
  // Pin drivers
  // *******************
  // Idle pins; strobes high so no access can start
  initial begin
    {mode, cs_n, ds_n, ws_n} = 4'h7;
    adr = 3'h0;
    din = 8'h00;
  end
  // one framed access, strobes held throughout
  task automatic xfer(input logic m, input logic w, input addr_t a, input byte_t d,
                      output byte_t rd, output logic ok);
    int i;
    @(negedge clk);
    mode = m;
    repeat (3) @(negedge clk);
    adr = a;
    din = w ? d : ~din;
    ds_n = !m && w;
    ws_n = !w;
    cs_n = 1'b0;
    for (i = 0; i < 20 && ack_n; i++) @(negedge clk);
    ok = (i < 20);
    for (i = 0; i < 20 && !m && !ack_n; i++) @(negedge clk);
    ok = ok && (ack_n === !m) && (i < 20);
    rd = oe_n ? 8'hxx : dout;
    // Hold past the edge that samples the answer, then release
    @(negedge clk);
    {cs_n, ds_n, ws_n} = 3'h7;
    din = ~din;
    repeat (4) @(negedge clk);
  endtask
  task automatic stray(output logic bad);
    bad = 1'b0;
    @(negedge clk);
    {ds_n, ws_n} = 2'h0;
    repeat (8) begin
      @(negedge clk);
      bad = bad | wstb | !ack_n | !oe_n;
    end
    {ds_n, ws_n} = 2'h3;
  endtask
endmodule

/* verif/tb_clocked_micro_port.sv */
/*
  Self-checking bench for clocked_micro_port with a host model.
  Assumes the checker file is compiled with it for its bind.
*/
`timescale 1ns/10ps
module tb_clocked_micro_port;
  import micro_port_pkg::*;
  logic  clk, mode, cs_n, ds_n, ws_n, oe_n, ack_n, wstb;
  logic  rst = 1'b1;
  addr_t adr, wadr;
  byte_t din, dout, wdat;
  int    n_fail = 0;
  int    n_checks = 0;
  // ***********************
  // Design and host model
  // ***********************
  clocked_micro_port clocked_micro_port_inst (.CLK(clk), .SYS_RST(rst), .MODE(mode), .CS_N(cs_n), .ADDR(adr),
    .DATA_STROBE_N(ds_n), .WRITE_SEL_N(ws_n), .D_I(din), .D_O(dout), .D_OE_N(oe_n), .TRANSFER_ACK_N(ack_n),
    .WR_STB(wstb), .WR_ADDR(wadr), .WR_DATA(wdat));
  micro_host micro_host_inst (.clk, .ack_n, .oe_n, .dout, .wstb, .mode, .cs_n, .adr, .ds_n, .ws_n, .din);
  // Clock
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic final_report;
    if (n_fail == 0 && n_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic t_idle;
    chk({ack_n, oe_n, wstb}, 8'h06);
  endtask
  // Back-to-back writes to every address, read back in the other mode
  task automatic t_burst(input logic mw, input logic mr);
    byte_t rd;
    logic  ok;
    for (int a = 0; a < 8; a++) begin
      micro_host_inst.xfer(mw, 1'b1, addr_t'(a), {mw, 4'h5, 3'(a)}, rd, ok);
      chk(8'(ok), 8'h01);
    end
    for (int a = 0; a < 8; a++) begin
      micro_host_inst.xfer(mr, 1'b0, addr_t'(a), 8'h00, rd, ok);
      chk(rd, {mw, 4'h5, 3'(a)});
    end
  endtask
  // Deselected strobes leave the store untouched
  task automatic t_stray;
    logic  bad;
    logic  ok;
    byte_t rd;
    micro_host_inst.stray(bad);
    chk(8'(bad), 8'h00);
    micro_host_inst.xfer(1'b1, 1'b0, 3'h3, 8'h00, rd, ok);
    chk(rd, 8'h2b);
  endtask
  // Main sequence
  initial begin
    repeat (12) @(negedge clk);
    rst = 1'b0;
    t_idle;
    t_burst(1'b1, 1'b0);
    t_burst(1'b0, 1'b1);
    t_stray;
    final_report;
  end
  // Watchdog at 5000 cycles, well beyond the few hundred cycles needed
  initial begin
    #50us;
    n_fail++;
    final_report;
  end
endmodule
